// File: hdl/atten_serial_pkg.sv
/*
  Constants, field layouts and carrier types for the step attenuator
  serial load front end.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package atten_serial_pkg;

  // Serial frame layout, first bit shifted in ends at bit 0
  localparam int          FRAME_W    = 16;
  localparam int          ATT_W      = 6;
  localparam int          ATT_LSB    = 1;
  localparam int          ADDR_LSB   = 8;
  localparam int          ADDR_W     = 3;
  localparam int          SYNC_W     = 8;

  // Reset values and low run counter constants
  localparam logic [ATT_W-1:0]   ATT_RESET   = 6'h3f;
  localparam logic [FRAME_W-1:0] FRAME_RESET = 16'h0000;
  localparam logic [4:0]         RUN_FULL    = 5'h10;
  localparam logic [4:0]         RUN_ZERO    = 5'h00;
  localparam logic [4:0]         RUN_ONE     = 5'h01;

  // Interface mode taken from the mode select pin
  typedef enum logic
  {
    MODE_PARALLEL = 1'b0,
    MODE_SERIAL   = 1'b1
  } mode_t;

  // Pin levels that cross into the system clock domain together
  typedef struct packed
  {
    logic             ser_par_sel;
    logic             strobe;
    logic [ADDR_W-1:0] chip_sel;
    logic             two_db_bit;
    logic             one_db_bit;
    logic             half_db_bit;
  } pins_t;

endpackage

// File: hdl/pin_sync.sv
/*
  Two flip-flop level synchroniser for a group of pin levels.
  Assumes each bit is a slow level; bits are not coherent as a word.
*/
`timescale 1ns/100ps
`default_nettype none

module pin_sync
#(
  parameter int WIDTH = 8
)
(
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Levels
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta;

  // First stage is read only by the second stage
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      meta     <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end

endmodule

`default_nettype wire

// File: hdl/step_attenuator_serial_load.sv
/*
  Serial load front end of a six-bit digital step attenuator: a 16-bit
  shift register clocked by the serial clock, a chained serial output,
  address compare, and the attenuation core latch on the system clock.
  Assumes the controller keeps the strobe high at least 30 ns and leaves
  the serial clock quiet while the strobe is high.
*/
`timescale 1ns/100ps
`default_nettype none

module step_attenuator_serial_load
  import atten_serial_pkg::*;
(
  // System clock and reset
  input  wire logic                       clk,
  input  wire logic                       rst,
  // Serial link, clock also serves as the 1 dB parallel bit
  input  wire logic                       sclk,
  input  wire logic                       load_strobe,
  input  wire logic                       serial_in,
  // Shared serial output / 2 dB parallel pin
  input  wire logic                       serial_out_pin,
  output var  logic                       serial_out,
  output var  logic                       serial_out_oe_n,
  // Mode select and address straps
  input  wire logic                       ser_par_sel,
  input  wire logic                       chip_sel_bit_low,
  input  wire logic                       chip_sel_bit_mid,
  input  wire logic                       chip_sel_bit_high,
  // Attenuation core
  output var  logic [ATT_W-1:0]           atten_state,
  output var  logic                       core_update,
  output var  logic                       addr_match
);

  // Link domain, clocked by the serial clock

  logic [FRAME_W-1:0] shift;
  logic [FRAME_W-1:0] next_shift;
  logic [4:0]         low_run;
  logic [4:0]         next_low_run;
  logic               next_serial_out;

  // Shift right so the first bit sent lands in bit 0 after a frame
  always_comb
  begin
    next_shift   = shift;
    next_low_run = RUN_ZERO;
    if (!load_strobe)
    begin
      next_shift   = {serial_in, shift[FRAME_W-1:1]};
      next_low_run = (low_run == RUN_FULL) ? RUN_FULL
                                           : low_run + RUN_ONE;
    end
  end

  // Cleared at reset, so the first frame pushes out zeros, not junk
  always_ff @(posedge sclk or posedge rst)
  begin
    if (rst)
    begin
      shift   <= FRAME_RESET;
      low_run <= RUN_ZERO;
    end
    else
    begin
      shift   <= next_shift;
      low_run <= next_low_run;
    end
  end

  // Bit 0 holds the oldest bit, so it is the next one to leave; a chained
  // device sees it sixteen rises after it entered here
  always_comb
  begin
    next_serial_out = shift[0];
  end

  // Output moves on the falling edge, so it is settled for the next rise
  always_ff @(negedge sclk or posedge rst)
  begin
    if (rst)
      serial_out <= 1'b0;
    else
      serial_out <= next_serial_out;
  end

  // System clock domain

  pins_t raw_pins;
  pins_t pins_s;
  logic  strobe_q;
  logic  strobe_rise;
  mode_t mode;

  // All pins are levels from outside this clock, so they get two flops
  always_comb
  begin
    raw_pins.ser_par_sel = ser_par_sel;
    raw_pins.strobe      = load_strobe;
    raw_pins.chip_sel    = {chip_sel_bit_high, chip_sel_bit_mid,
                            chip_sel_bit_low};
    raw_pins.two_db_bit  = serial_out_pin;
    raw_pins.one_db_bit  = sclk;
    raw_pins.half_db_bit = serial_in;
  end

  pin_sync
  #(
    .WIDTH    (SYNC_W)
  )
  u_pin_sync
  (
    .clk      (clk),
    .rst      (rst),
    .async_in (raw_pins),
    .sync_out (pins_s)
  );

  assign mode        = mode_t'(pins_s.ser_par_sel);
  assign strobe_rise = pins_s.strobe & ~strobe_q;

  // Release the shared pin in parallel mode so it can be an input
  assign serial_out_oe_n = (mode == MODE_SERIAL) ? 1'b0 : 1'b1;

  // Address compare against the straps; upper address bits are ignored
  function automatic logic frame_hits(input logic [FRAME_W-1:0] frame,
                                      input logic [ADDR_W-1:0]  straps);
    frame_hits = (frame[ADDR_LSB +: ADDR_W] == straps);
  endfunction

  // Parallel word in bit order 0.5, 1, 2, 4, 8, 16 dB
  function automatic logic [ATT_W-1:0] parallel_word(input pins_t p);
    parallel_word = {p.chip_sel, p.two_db_bit, p.one_db_bit,
                     p.half_db_bit};
  endfunction

  logic [ATT_W-1:0] next_atten_state;
  logic             next_core_update;
  logic             next_addr_match;
  logic             hit;

  // The shift register is frozen while the strobe is high, so it is a
  // stable word when the synchronised rise is seen here. Limitation: a
  // strobe narrower than about three system clocks may be missed.
  assign hit = frame_hits(shift, pins_s.chip_sel);

  always_comb
  begin
    next_atten_state = atten_state;
    next_core_update = 1'b0;
    next_addr_match  = addr_match;
    unique case (mode)
      MODE_SERIAL:
      begin
        if (strobe_rise)
        begin
          next_addr_match = hit;
          if (hit)
          begin
            next_atten_state = shift[ATT_LSB +: ATT_W];
            next_core_update = 1'b1;
          end
        end
      end
      MODE_PARALLEL:
      begin
        // Strobe high follows the pins; its rise pulses the core update
        if (pins_s.strobe)
        begin
          next_atten_state = parallel_word(pins_s);
          next_core_update = strobe_rise;
        end
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      strobe_q    <= 1'b0;
      atten_state <= ATT_RESET;
      core_update <= 1'b0;
      addr_match  <= 1'b0;
    end
    else
    begin
      strobe_q    <= pins_s.strobe;
      atten_state <= next_atten_state;
      core_update <= next_core_update;
      addr_match  <= next_addr_match;
    end
  end

  // Checks. System clock properties look at the synchronised pins, so they
  // see the same view as the latch; link properties run on the serial
  // clock and watch the shift register directly.

  sequence serial_rise_s;
    mode == MODE_SERIAL && strobe_rise;
  endsequence

  property latch_on_hit_p;
    @(posedge clk) disable iff (rst)
      serial_rise_s and hit |=>
        atten_state == $past(shift[ATT_LSB +: ATT_W]) && core_update;
  endproperty

  latch_on_hit_a : assert property (latch_on_hit_p)
    else $error("core not loaded on matching strobe");

  miss_holds_a : assert property (
    @(posedge clk) disable iff (rst)
      serial_rise_s and !hit |=> $stable(atten_state) && !core_update)
    else $error("core changed on address mismatch");

  strobe_only_a : assert property (
    @(posedge clk) disable iff (rst)
      mode == MODE_SERIAL && !strobe_rise
        && $stable(mode) |=> $stable(atten_state))
    else $error("core changed without a strobe rise");

  shift_hold_a : assert property (
    @(posedge sclk) disable iff (rst)
      load_strobe |=> $stable(shift))
    else $error("shift register moved while strobe high");

  chain_delay_a : assert property (
    @(posedge sclk) disable iff (rst)
      low_run == RUN_FULL |-> serial_out == $past(serial_in, 16))
    else $error("chained output not sixteen clocks late");

  lsb_first_a : assert property (
    @(posedge sclk) disable iff (rst)
      !load_strobe |=> shift[FRAME_W-1] == $past(serial_in))
    else $error("serial bit not taken on rising edge");

  sequence par_follow_s;
    mode == MODE_PARALLEL && pins_s.strobe ##0 $stable(mode);
  endsequence

  par_map_a : assert property (
    @(posedge clk) disable iff (rst)
      par_follow_s |=> atten_state == $past(parallel_word(pins_s)))
    else $error("parallel bits not mapped to core");

  pin_release_a : assert property (
    @(posedge clk) disable iff (rst)
      mode == MODE_PARALLEL |-> serial_out_oe_n)
    else $error("shared output pin driven in parallel mode");

  drive_serial_a : assert property (
    @(posedge clk) disable iff (rst)
      mode == MODE_SERIAL |-> !serial_out_oe_n)
    else $error("shared output pin released in serial mode");

  update_pulse_a : assert property (
    @(posedge clk) disable iff (rst)
      core_update |=> !core_update)
    else $error("update pulse longer than one cycle");

  // A load pulse with no strobe rise behind it would glitch the core
  no_stray_update_a : assert property (
    @(posedge clk) disable iff (rst)
      !strobe_rise |=> !core_update)
    else $error("update pulse without a strobe rise");

  match_flag_a : assert property (
    @(posedge clk) disable iff (rst)
      serial_rise_s |=> addr_match == $past(hit))
    else $error("address match flag not taken at strobe rise");

  sequence par_rise_s;
    mode == MODE_PARALLEL && strobe_rise;
  endsequence

  par_pulse_a : assert property (
    @(posedge clk) disable iff (rst)
      par_rise_s |=> core_update)
    else $error("no update pulse on parallel strobe rise");

  par_hold_a : assert property (
    @(posedge clk) disable iff (rst)
      mode == MODE_PARALLEL && !pins_s.strobe
        && $stable(mode) |=> $stable(atten_state))
    else $error("parallel core moved with the strobe low");

  shift_adv_a : assert property (
    @(posedge sclk) disable iff (rst)
      !load_strobe |=> shift[FRAME_W-2:0] == $past(shift[FRAME_W-1:1]))
    else $error("shift register did not move one place");

endmodule

`default_nettype wire

// File: tb/link_ctrl_model.sv
/*
  Controller model for the serial link: clock, data and strobe.
  Assumes the bench calls its tasks from a single process.
*/
`timescale 1ns/100ps
`default_nettype none

module link_ctrl_model
(
  // Link pins toward the device
  output var  logic        sclk,
  output var  logic        load_strobe,
  output var  logic        serial_in,
  // Chained output and system clock
  input  wire logic        serial_out,
  input  wire logic        clk,
  // Chained bits seen at each rise
  output var  logic [31:0] seen
);
  initial
  begin
    sclk        = 1'b0;
    load_strobe = 1'b0;
    serial_in   = 1'b0;
    seen        = 32'h0;
  end

  // Clock runs only inside a frame; data moves at the fall
  task automatic shift(input logic [31:0] bits, input int n);
    #1.7;
    for (int k = 0; k < n; k++)
    begin
      serial_in = bits[k];
      #3 sclk = 1'b1;
      seen[k] = serial_out;
      #3 sclk = 1'b0;
    end
    serial_in = ~serial_in;  // Released line keeps no stale bit
  endtask

  // Strobe moves on the system clock so its width is kept
  task automatic strobe(input logic v);
    @(posedge clk) load_strobe <= v;
  endtask

  // Parallel mode levels on the shared clock and data pins
  task automatic par(input logic c, input logic d);
    sclk      <= c;
    serial_in <= d;
  endtask
endmodule
`default_nettype wire

// File: tb/testbench.sv
/*
  Self-checking bench for the attenuator serial load front end.
  Assumes the package, the design and the controller model are built.
*/
`timescale 1ns/100ps
`default_nettype none

module testbench;
  import atten_serial_pkg::*;

  localparam logic [2:0] CS = 3'h5;

  logic             clk;
  logic             rst;
  logic             ser_par_sel;
  logic [2:0]       cs;
  logic             d2db;
  logic             sclk;
  logic             load_strobe;
  logic             serial_in;
  logic             so_pin;
  logic             serial_out;
  logic             serial_out_oe_n;
  logic [ATT_W-1:0] atten_state;
  logic             core_update;
  logic             addr_match;
  logic [31:0]      seen;
  int               error_cnt;
  int               num_checks;

  // Shared pin: device drives it while its enable is low
  assign so_pin = serial_out_oe_n ? d2db : serial_out;

  step_attenuator_serial_load uut
  (
    .clk               (clk),
    .rst               (rst),
    .sclk              (sclk),
    .load_strobe       (load_strobe),
    .serial_in         (serial_in),
    .serial_out_pin    (so_pin),
    .serial_out        (serial_out),
    .serial_out_oe_n   (serial_out_oe_n),
    .ser_par_sel       (ser_par_sel),
    .chip_sel_bit_low  (cs[0]),
    .chip_sel_bit_mid  (cs[1]),
    .chip_sel_bit_high (cs[2]),
    .atten_state       (atten_state),
    .core_update       (core_update),
    .addr_match        (addr_match)
  );

  link_ctrl_model ctrl
  (
    .sclk        (sclk),
    .load_strobe (load_strobe),
    .serial_in   (serial_in),
    .serial_out  (so_pin),
    .clk         (clk),
    .seen        (seen)
  );

  // System clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic finish_test();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Address byte above attenuation byte; unused bits sent low
  function automatic logic [15:0] frm(input logic [2:0] a,
                                      input logic [5:0] v);
    return {5'h00, a, 1'b0, v, 1'b0};
  endfunction

  // Strobe pulse; the load pulse is looked for within a bounded wait
  task automatic load(input logic exp);
    logic hit;
    hit = 1'b0;
    ctrl.strobe(1'b1);
    repeat (8)
    begin
      @(posedge clk);
      #1;
      if (core_update === 1'b1)
        hit = 1'b1;
    end
    chk(16'(hit), 16'(exp));
    ctrl.strobe(1'b0);
    repeat (4) @(posedge clk);
    if (exp && !hit)
      finish_test();
  endtask

  task automatic s_load();
    chk(16'(atten_state), 16'(ATT_RESET));
    chk(16'(addr_match), 16'h0);
    chk(16'(serial_out_oe_n), 16'h0);
    ctrl.shift(32'(frm(CS, 6'h2a)), 16);  // chained bits not judged
    load(1'b1);
    chk(16'(atten_state), 16'h2a);
    chk(16'(addr_match), 16'h1);
    ctrl.shift(32'(frm(CS, 6'h15)), 16);
    load(1'b1);
    chk(16'(atten_state), 16'h15);
  endtask

  task automatic s_miss();
    ctrl.shift(32'(frm(3'h2, 6'h3c)), 16);
    load(1'b0);
    chk(16'(atten_state), 16'h15);
    chk(16'(addr_match), 16'h0);
  endtask

  // Edges while the strobe is high must not reach the register
  task automatic s_hold();
    ctrl.shift(32'(frm(CS, 6'h33)), 16);
    ctrl.strobe(1'b1);
    repeat (6) @(posedge clk);
    ctrl.shift(32'(frm(CS, 6'h0c)), 16);
    ctrl.strobe(1'b0);
    repeat (4) @(posedge clk);
    load(1'b1);
    chk(16'(atten_state), 16'h33);
  endtask

  // Two frames in one strobe window, far frame first
  task automatic s_chain();
    ctrl.shift({frm(CS, 6'h07), frm(3'h2, 6'h3c)}, 32);
    chk(seen[15:0], frm(CS, 6'h33));
    chk(seen[31:16], frm(3'h2, 6'h3c));
    load(1'b1);
    chk(16'(atten_state), 16'h07);
  endtask

  // Direct parallel mode: the shared pins set the core
  task automatic s_par();
    logic [5:0] v;
    ctrl.par(1'b0, 1'b0);
    @(posedge clk);
    cs <= 3'h0;
    ser_par_sel <= 1'b0;
    repeat (4) @(posedge clk);
    chk(16'(serial_out_oe_n), 16'h1);
    ctrl.strobe(1'b1);
    for (int i = 0; i < 2; i++)
    begin
      v = i ? 6'h15 : 6'h2a;
      @(posedge clk);
      cs <= v[5:3];
      d2db <= v[2];
      ctrl.par(v[1], v[0]);
      repeat (6) @(posedge clk);
      #1;
      chk(16'(atten_state), 16'(v));
    end
  endtask

  initial
  begin
    rst         = 1'b1;
    ser_par_sel = 1'b1;
    cs          = CS;
    d2db        = 1'b0;
    error_cnt   = 0;
    num_checks  = 0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    s_load();
    s_miss();
    s_hold();
    s_chain();
    s_par();
    finish_test();
  end
endmodule
`default_nettype wire
